// ### verilog/tdc_pkg.sv
// thermal/dither configuration constants: register indices, fields, reset values, timing.
// assumes a 125 MHz system clock; byte address of a register is four times its index.
package tdc_pkg;
    localparam int          CLK_MHZ          = 125;
    localparam int          CLK_PERIOD_PS    = 1_000_000 / CLK_MHZ;
    // register indices; byte address = index * 4
    localparam logic [7:0]  IDX_SHUTDOWN_CTRL = 8'h5a;
    localparam logic [7:0]  IDX_THRESH_SAT    = 8'h5b;
    localparam logic [7:0]  IDX_CAL_DELAY     = 8'h5c;
    localparam logic [7:0]  IDX_DITHER        = 8'h5d;
    localparam logic [7:0]  IDX_CH_OFFSET     = 8'h5e;
    localparam logic [7:0]  IDX_WAKEUP_OFS    = 8'h60;
    localparam logic [7:0]  IDX_STATUS        = 8'h61;
    // field positions
    localparam int          THRESH_LSB        = 3;
    localparam int          CLAMP_LSB         = 0;
    localparam int          CAL_DIS_BIT       = 6;
    localparam int          DELAY_LSB         = 2;
    localparam int          NODIM_BIT         = 7;
    localparam int          DEPTH_LSB         = 5;
    localparam int          RED_CH_BIT        = 4;
    localparam int          SHUT_OFS_LSB      = 4;
    localparam int          DIM_EN_BIT        = 0;
    // reset values
    localparam logic [7:0]  RST_THRESH_SAT    = 8'h00;
    localparam logic [7:0]  RST_CAL_DELAY     = 8'h00;
    localparam logic [7:0]  RST_DITHER        = 8'h00;
    localparam logic [7:0]  RST_CH_OFFSET     = 8'h00;
    localparam logic [7:0]  RST_SHUTDOWN_CTRL = 8'h00;
    localparam logic [7:0]  RST_WAKEUP_OFS    = 8'h00;
    // thermal threshold code = base + step * field
    localparam logic [8:0]  THRESH_BASE       = 9'h050;
    localparam int          THRESH_STEP_SH    = 2;
    localparam int          SHUT_STEP_SH      = 2;
    // dither reference variation in tenths of a percent, per depth code
    localparam logic [6:0]  DITHER_VAR_00     = 7'h0d;
    localparam logic [6:0]  DITHER_VAR_01     = 7'h1d;
    localparam logic [6:0]  DITHER_VAR_10     = 7'h3c;
    localparam logic [6:0]  DITHER_VAR_11     = 7'h7b;
    // turn-on compensation step; least time, rounded up to whole cycles
    localparam int          COMP_STEP_NS      = 50;
    localparam int          COMP_STEP_CYC     = (COMP_STEP_NS * 1000 + CLK_PERIOD_PS - 1)
                                                / CLK_PERIOD_PS;
endpackage : tdc_pkg

// ### verilog/tdc_comp_if.sv
// start/done handshake between register bank and the turn-on compensation timer.
// assumes both ends run on the same clock.
`timescale 1ns/10ps
interface tdc_comp_if;
    logic       start;
    logic [2:0] delay_code;
    logic       sense_ok;
    modport ctrl  (output start, output delay_code, input sense_ok);
    modport timer (input start, input delay_code, output sense_ok);
endinterface : tdc_comp_if

// ### verilog/tdc_comp_timer.sv
// turn-on compensation timer: holds the sense comparison off after switch turn-on.
// assumes start is a one-cycle pulse on the system clock.
`timescale 1ns/10ps
module tdc_comp_timer
    import tdc_pkg::*;
#(
    parameter int STEP_CYC = COMP_STEP_CYC
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // control side
    tdc_comp_if.timer cif
);
    logic [7:0] remain;

    // code times step, counted down; code 0 gives no blanking
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            remain <= 8'h00;
        end else if (cif.start) begin
            remain <= 8'(int'(cif.delay_code) * STEP_CYC);
        end else if (remain != 8'h00) begin
            remain <= remain - 8'h01;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cif.sense_ok <= 1'b0;
        end else if (cif.start) begin
            cif.sense_ok <= (cif.delay_code == 3'h0);
        end else if (remain == 8'h01) begin
            cif.sense_ok <= 1'b1;
        end
    end
endmodule : tdc_comp_timer

// ### verilog/tdc_regs.sv
// thermal threshold and dither configuration bank with Avalon-MM slave.
// assumes measured temperature and mode inputs come from logic on i_clk;
// the switch gate pin arrives asynchronously and is synchronised here.
`timescale 1ns/10ps
// Notes on behaviour
// - sense comparison held off for delay field times seven cycles (56 ns, fifty rounded up) after turn-on.
// - dither runs in all modes, or only without dimmer when restriction bit set.
// - dither reference varies 1.3, 2.9, 6 or 12.3 percent per depth code.
// - reduced dither applies to channel one for 0, channel two for 1.
// - with temperature dimming on, code above threshold reduces second-stage dim.
// - shutdown code is wakeup code plus four times offset; wakeup above threshold.
module tdc_regs
    import tdc_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // avalon-mm slave
    input  wire logic [9:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // device status inputs
    input  wire logic [7:0]  i_therm_code,
    input  wire logic        i_dither_enable,
    input  wire logic        i_no_dimmer,
    input  wire logic        i_switch_gate,
    // configuration outputs
    output logic      [7:0]  o_thermal_threshold,
    output logic      [7:0]  o_shutdown_code,
    output logic             o_dim_reduce,
    output logic             o_overtemp,
    output logic             o_line_calibration_en,
    output logic             o_sense_enable,
    output logic             o_dither_active,
    output logic      [6:0]  o_dither_variation,
    output logic      [1:0]  o_dither_reduced_ch,
    output logic      [2:0]  o_upper_temp_clamp,
    output logic      [7:0]  o_channel_offset
);
    logic [4:0] thermal_dim_threshold;
    logic [2:0] upper_temp_clamp;
    logic       line_calibration_disable;
    logic [2:0] turn_on_compensation_time;
    logic       dither_nodimmer_only;
    logic [1:0] dither_depth;
    logic       dither_reduced_channel;
    logic [7:0] channel_offset_config;
    logic [3:0] shutdown_offset;
    logic       dim_temp_en;
    logic [7:0] wakeup_offset;
    logic       wait_q;
    logic [7:0] idx;
    logic       wr_go;
    logic [7:0] next_rdata;
    logic       gate_s1;
    logic       gate_s2;
    logic       gate_d;
    logic [8:0] thresh_sum;
    logic [8:0] wake_sum;
    logic [9:0] shut_sum;
    logic [7:0] thresh_code;
    logic [7:0] shut_code;

    tdc_comp_if cif ();

    assign idx   = i_avs_address[9:2];
    assign wr_go = i_avs_write && !wait_q;

    // one wait cycle per access, then a single-cycle answer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_q <= 1'b1;
        end else if ((i_avs_read || i_avs_write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    assign o_avs_waitrequest = wait_q;

    always_comb begin
        next_rdata = 8'h00;
        case (idx)
            IDX_SHUTDOWN_CTRL: next_rdata = {shutdown_offset, 3'h0, dim_temp_en};
            IDX_THRESH_SAT:    next_rdata = {thermal_dim_threshold, upper_temp_clamp};
            IDX_CAL_DELAY:     next_rdata = {1'b0, line_calibration_disable, 1'b0,
                                             turn_on_compensation_time, 2'h0};
            IDX_DITHER:        next_rdata = {dither_nodimmer_only, dither_depth,
                                             dither_reduced_channel, 4'h0};
            IDX_CH_OFFSET:     next_rdata = channel_offset_config;
            IDX_WAKEUP_OFS:    next_rdata = wakeup_offset;
            IDX_STATUS:        next_rdata = {5'h00, o_sense_enable, o_overtemp, o_dim_reduce};
            default:           next_rdata = 8'h00;
        endcase
    end

    // unmapped reads return zero; reserved bits read zero
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && wait_q) begin
            o_avs_readdata <= {24'h00_0000, next_rdata};
        end
    end

    // register writes; unmapped writes and the status word are ignored
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            {shutdown_offset, dim_temp_en}             <= {RST_SHUTDOWN_CTRL[7:4],
                                                           RST_SHUTDOWN_CTRL[0]};
            {thermal_dim_threshold, upper_temp_clamp} <= RST_THRESH_SAT;
            line_calibration_disable                  <= RST_CAL_DELAY[CAL_DIS_BIT];
            turn_on_compensation_time                 <= RST_CAL_DELAY[DELAY_LSB +: 3];
            {dither_nodimmer_only, dither_depth, dither_reduced_channel} <= RST_DITHER[7:4];
            channel_offset_config                     <= RST_CH_OFFSET;
            wakeup_offset                             <= RST_WAKEUP_OFS;
        end else if (wr_go) begin
            case (idx)
                IDX_SHUTDOWN_CTRL: begin
                    shutdown_offset <= i_avs_writedata[SHUT_OFS_LSB +: 4];
                    dim_temp_en     <= i_avs_writedata[DIM_EN_BIT];
                end
                IDX_THRESH_SAT: begin
                    thermal_dim_threshold <= i_avs_writedata[THRESH_LSB +: 5];
                    upper_temp_clamp      <= i_avs_writedata[CLAMP_LSB +: 3];
                end
                IDX_CAL_DELAY: begin
                    line_calibration_disable  <= i_avs_writedata[CAL_DIS_BIT];
                    turn_on_compensation_time <= i_avs_writedata[DELAY_LSB +: 3];
                end
                IDX_DITHER: begin
                    dither_nodimmer_only   <= i_avs_writedata[NODIM_BIT];
                    dither_depth           <= i_avs_writedata[DEPTH_LSB +: 2];
                    dither_reduced_channel <= i_avs_writedata[RED_CH_BIT];
                end
                IDX_CH_OFFSET:  channel_offset_config <= i_avs_writedata[7:0];
                IDX_WAKEUP_OFS: wakeup_offset         <= i_avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // thermal codes; the shutdown sum saturates at 0xff so a large offset cannot wrap below threshold
    assign thresh_sum  = THRESH_BASE + {2'h0, thermal_dim_threshold, 2'h0};
    assign thresh_code = thresh_sum[7:0];
    assign wake_sum    = {1'b0, thresh_code} + {1'b0, wakeup_offset};
    assign shut_sum    = {1'b0, wake_sum} + {4'h0, shutdown_offset, 2'h0};
    assign shut_code   = (shut_sum > 10'h0ff) ? 8'hff : shut_sum[7:0];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_thermal_threshold <= 8'h00;
            o_shutdown_code     <= 8'h00;
            o_dim_reduce        <= 1'b0;
            o_overtemp          <= 1'b0;
        end else begin
            o_thermal_threshold <= thresh_code;
            o_shutdown_code     <= shut_code;
            o_dim_reduce        <= dim_temp_en && (i_therm_code > thresh_code);
            o_overtemp          <= i_therm_code > shut_code;
        end
    end

    // dither, calibration, clamp and channel offset controls
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_line_calibration_en <= 1'b0;
            o_dither_active       <= 1'b0;
            o_dither_variation    <= DITHER_VAR_00;
            o_dither_reduced_ch   <= 2'h0;
            o_upper_temp_clamp    <= 3'h0;
            o_channel_offset      <= 8'h00;
        end else begin
            o_line_calibration_en <= !line_calibration_disable;
            o_dither_active       <= i_dither_enable
                                     && (!dither_nodimmer_only || i_no_dimmer);
            case (dither_depth)
                2'h0:    o_dither_variation <= DITHER_VAR_00;
                2'h1:    o_dither_variation <= DITHER_VAR_01;
                2'h2:    o_dither_variation <= DITHER_VAR_10;
                default: o_dither_variation <= DITHER_VAR_11;
            endcase
            o_dither_reduced_ch   <= dither_reduced_channel ? 2'h2 : 2'h1;
            o_upper_temp_clamp    <= upper_temp_clamp;
            o_channel_offset      <= channel_offset_config;
        end
    end

    // gate pin is asynchronous: two flops before the edge detector
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gate_s1 <= 1'b0;
            gate_s2 <= 1'b0;
            gate_d  <= 1'b0;
        end else begin
            gate_s1 <= i_switch_gate;
            gate_s2 <= gate_s1;
            gate_d  <= gate_s2;
        end
    end

    assign cif.start      = gate_s2 && !gate_d;
    assign cif.delay_code = turn_on_compensation_time;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sense_enable <= 1'b0;
        end else begin
            o_sense_enable <= cif.sense_ok;
        end
    end

    tdc_comp_timer #(
        .STEP_CYC (COMP_STEP_CYC)
    ) u_comp_timer (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .cif   (cif.timer)
    );
endmodule : tdc_regs

// ### tb/tdc_regs_sva.sv
// assertion checker for the thermal/dither register bank, bound onto tdc_regs.
// assumes one wait cycle per access and outputs that follow a write two edges later.
`timescale 1ns/10ps
module tdc_regs_sva
    import tdc_pkg::*;
(
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    // avalon-mm slave
    input wire logic [9:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    // status inputs
    input wire logic [7:0]  i_therm_code,
    input wire logic        i_dither_enable,
    input wire logic        i_no_dimmer,
    input wire logic        i_switch_gate,
    // configuration outputs
    input wire logic [7:0]  o_thermal_threshold,
    input wire logic [7:0]  o_shutdown_code,
    input wire logic        o_dim_reduce,
    input wire logic        o_overtemp,
    input wire logic        o_line_calibration_en,
    input wire logic        o_sense_enable,
    input wire logic        o_dither_active,
    input wire logic [6:0]  o_dither_variation,
    input wire logic [1:0]  o_dither_reduced_ch,
    input wire logic [2:0]  o_upper_temp_clamp,
    input wire logic [7:0]  o_channel_offset
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic       wr_done;
    logic [7:0] idx;
    assign wr_done = i_avs_write && !o_avs_waitrequest;
    assign idx     = i_avs_address[9:2];
    function automatic logic [6:0] var_of(input logic [1:0] d);
        case (d)
            2'h0:    return 7'h0d;
            2'h1:    return 7'h1d;
            2'h2:    return 7'h3c;
            default: return 7'h7b;
        endcase
    endfunction : var_of
    chk_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("waitrequest not low after request");
    chk_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_thresh_calc: assert property (wr_done && idx == IDX_THRESH_SAT |=> ##1
        o_thermal_threshold == 8'h50 + {$past(i_avs_writedata[7:3], 2), 2'b00})
        else $error("threshold code wrong after write");
    chk_line_cal: assert property (wr_done && idx == IDX_CAL_DELAY |=> ##1
        o_line_calibration_en == !$past(i_avs_writedata[6], 2))
        else $error("line calibration enable wrong");
    chk_depth_map: assert property (wr_done && idx == IDX_DITHER |=> ##1
        o_dither_variation == var_of($past(i_avs_writedata[6:5], 2)))
        else $error("dither variation wrong");
    chk_chan_select: assert property (wr_done && idx == IDX_DITHER |=> ##1
        o_dither_reduced_ch == ($past(i_avs_writedata[4], 2) ? 2'b10 : 2'b01))
        else $error("reduced dither channel wrong");
    chk_dither_off: assert property (!i_dither_enable |=> !o_dither_active)
        else $error("dither active while disabled");
    chk_dither_nodim: assert property (i_dither_enable && i_no_dimmer
        |=> o_dither_active) else $error("dither idle without dimmer");
    // a write in flight may move the threshold under the comparison
    chk_dim_quiet: assert property (!$past(i_avs_write)
        && i_therm_code <= o_thermal_threshold |=> !o_dim_reduce)
        else $error("dim reduce at or below threshold");
    cover property (wr_done && idx == IDX_DITHER);
    cover property (o_dim_reduce);
    cover property (o_overtemp);
    cover property ($fell(o_sense_enable));
endmodule : tdc_regs_sva
bind tdc_regs tdc_regs_sva i_sva (.*);

// ### tb/tb.sv
// self-checking bench for the thermal/dither register bank.
// assumes a 125 MHz clock and the bank's one-wait-cycle avalon-mm slave.
`timescale 1ns/10ps
module tb;
    import tdc_pkg::*;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
    logic [9:0]  i_avs_address = 10'h000;
    logic [31:0] i_avs_writedata = 32'h0000_0000, o_avs_readdata, rdat;
    logic [7:0]  i_therm_code = 8'h00, o_thermal_threshold, o_shutdown_code, o_channel_offset;
    logic        i_dither_enable = 1'b0, i_no_dimmer = 1'b0, i_switch_gate = 1'b0;
    logic        o_avs_waitrequest, o_dim_reduce, o_overtemp, o_line_calibration_en;
    logic        o_sense_enable, o_dither_active;
    logic [6:0]  o_dither_variation;
    logic [1:0]  o_dither_reduced_ch;
    logic [2:0]  o_upper_temp_clamp;
    logic [6:0]  vt[4] = '{7'h0d, 7'h1d, 7'h3c, 7'h7b};
    logic [4:0]  fl[3] = '{5'h00, 5'h01, 5'h1f};
    logic [7:0]  tv[4] = '{8'h64, 8'h65, 8'h78, 8'h79};
    int          n_fail = 0, total_checks = 0, lo;
    always #4 i_clk = ~i_clk;
    tdc_regs i_dut (.*);
    task automatic end_of_test;
        if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // one access; request held until waitrequest is sampled low
    task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        @(posedge i_clk);
        i_avs_address <= {idx, 2'b00};
        i_avs_writedata <= {24'h00_0000, d};
        i_avs_write <= wr;
        i_avs_read <= !wr;
        do begin
            @(posedge i_clk);
        end while (o_avs_waitrequest !== 1'b0);
        rdat = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask : acc
    task automatic settle;
        repeat (3) @(posedge i_clk);
    endtask : settle
    initial begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        end_of_test;
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        settle;
        chk("threshold", 8'h50, o_thermal_threshold);
        chk("shutdown", 8'h50, o_shutdown_code);
        chk("cal_en", 1'b1, o_line_calibration_en);
        chk("red_ch", 2'b01, o_dither_reduced_ch);
        for (int k = 0; k < 3; k++) begin
            acc(1'b1, IDX_THRESH_SAT, {fl[k], 3'h5});
            acc(1'b0, IDX_THRESH_SAT, 8'h00);
            settle;
            chk("thresh_reg", {fl[k], 3'h5}, rdat);
            chk("threshold", 8'h50 + {fl[k], 2'b00}, o_thermal_threshold);
            chk("clamp", 3'h5, o_upper_temp_clamp);
        end
        acc(1'b1, IDX_CAL_DELAY, 8'hff);
        acc(1'b0, IDX_CAL_DELAY, 8'h00);
        settle;
        chk("cal_reg", 8'h5c, rdat);
        chk("cal_en", 1'b0, o_line_calibration_en);
        // sense is low out of reset: one long pulse with code 7 raises it first
        i_switch_gate <= 1'b1;
        repeat (60) @(posedge i_clk);
        chk("sense_primed", 1'b1, o_sense_enable);
        i_switch_gate <= 1'b0;
        // longest code first so sense is known high before code 0
        for (int c = 6; c >= 0; c -= 3) begin
            acc(1'b1, IDX_CAL_DELAY, {3'h0, c[2:0], 2'h0});
            settle;
            chk("cal_en", 1'b1, o_line_calibration_en);
            i_switch_gate <= 1'b1;
            lo = 0;
            repeat (80) begin
                @(posedge i_clk);
                if (o_sense_enable !== 1'b1) lo++;
            end
            i_switch_gate <= 1'b0;
            chk("sense_low", 1'b1,
                lo >= c * COMP_STEP_CYC && lo <= c * COMP_STEP_CYC + 1);
        end
        for (int k = 0; k < 8; k++) begin
            acc(1'b1, IDX_DITHER, {k[2], k[1:0], k[2], 4'hf});
            acc(1'b0, IDX_DITHER, 8'h00);
            settle;
            chk("dither_reg", {k[2], k[1:0], k[2], 4'h0}, rdat);
            chk("variation", vt[k[1:0]], o_dither_variation);
            chk("red_ch", k[2] ? 2'b10 : 2'b01, o_dither_reduced_ch);
            for (int m = 0; m < 4; m++) begin
                i_dither_enable <= m[0];
                i_no_dimmer <= m[1];
                settle;
                chk("dither_act", m[0] && (!k[2] || m[1]), o_dither_active);
            end
        end
        acc(1'b1, IDX_THRESH_SAT, 8'h28);
        acc(1'b1, IDX_WAKEUP_OFS, 8'h08);
        acc(1'b1, IDX_SHUTDOWN_CTRL, 8'h31);
        for (int k = 0; k < 4; k++) begin
            i_therm_code <= tv[k];
            settle;
            chk("shutdown", 8'h78, o_shutdown_code);
            chk("dim_reduce", tv[k] > 8'h64, o_dim_reduce);
            chk("overtemp", tv[k] > 8'h78, o_overtemp);
        end
        acc(1'b0, IDX_STATUS, 8'h00);
        chk("status", 3'b111, rdat[2:0]);
        acc(1'b1, IDX_SHUTDOWN_CTRL, 8'h30);
        settle;
        chk("dim_reduce", 1'b0, o_dim_reduce);
        acc(1'b1, IDX_CH_OFFSET, 8'ha5);
        acc(1'b1, 8'h70, 8'hff);
        acc(1'b0, 8'h70, 8'h00);
        chk("unmapped", 32'h0000_0000, rdat);
        acc(1'b0, IDX_CH_OFFSET, 8'h00);
        chk("ch_off_reg", 8'ha5, rdat);
        chk("ch_offset", 8'ha5, o_channel_offset);
        end_of_test;
    end
endmodule : tb
